// ---- trace_timestamp_packet_encoder.sv ----
// Local and global timestamp packet encoder for a byte-wide trace stream.
// Assumes sources present one-cycle requests and the sink stalls with out_ready.
//
// Local design decisions: the placing of the registers and register access over APB.
`default_nettype none

module trace_timestamp_packet_encoder (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // APB register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Stamp requests
  input wire stamp_enc_pkg::local_req_type local_req,
  input wire stamp_enc_pkg::global_req_type global_req,
  input wire logic clock_change,
  // Byte stream to the trace port unit
  output logic [7:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  stamp_enc_pkg::enc_state_type state_ff, nxt_state;
  logic [7:0] out_data_ff, nxt_out_data;
  logic out_valid_ff, nxt_out_valid;
  logic [5:0][7:0] buf_ff, nxt_buf;
  logic [2:0] rem_ff, nxt_rem;
  logic [stamp_enc_pkg::LOCAL_WIDTH-1:0] ctr_ff, nxt_ctr;
  logic ovf_pend_ff, nxt_ovf_pend;
  logic clk_flag_ff, nxt_clk_flag;
  logic full_req_ff, nxt_full_req;
  logic hi_pend_ff, nxt_hi_pend;
  logic [stamp_enc_pkg::GLOBAL_HIGH_WIDTH-1:0] hi_q_ff, nxt_hi_q;
  logic [stamp_enc_pkg::GLOBAL_HIGH_WIDTH-1:0] hi_last_ff, nxt_hi_last;
  logic [stamp_enc_pkg::GLOBAL_LOW_WIDTH-1:0] low_last_ff, nxt_low_last;
  logic [stamp_enc_pkg::DROPS_WIDTH-1:0] drops_ff, nxt_drops;
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;

  // Launch decode
  logic idle;
  logic sel_ovf, sel_lts, sel_gl, sel_gh;
  logic lts_single, gl_wrap, gl_full;
  logic [3:0] lts_nz, gl_nz;
  logic [2:0] lts_len, gl_cnt, gl_len;
  logic [6:0][7:0] pkt;
  logic [2:0] pkt_rem;
  logic [stamp_enc_pkg::GLOBAL_LOW_WIDTH-1:0] ts_low;
  logic [stamp_enc_pkg::GLOBAL_HIGH_WIDTH-1:0] ts_high;
  logic [6:0] gl_grp3;
  logic apb_setup, apb_wr;

  assign ts_low = global_req.stamp_value_field[stamp_enc_pkg::GLOBAL_LOW_WIDTH-1:0];
  assign ts_high = global_req.stamp_value_field[stamp_enc_pkg::GLOBAL_WIDTH-1:
                                                stamp_enc_pkg::GLOBAL_LOW_WIDTH];

  ////////////////////////////////////////////////////////////////////////////
  // Group compression
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lts_nz[i] = |ctr_ff[i*7 +: 7];
    end
    for (int i = 0; i < 3; i++) begin
      gl_nz[i] = ts_low[i*7 +: 7] != low_last_ff[i*7 +: 7];
    end
    gl_nz[3] = ts_low[25:21] != low_last_ff[25:21];
  end

  stamp_group_len u_local_len (
    .group_nz(lts_nz),
    .byte_cnt(lts_len)
  );

  stamp_group_len u_global_len (
    .group_nz(gl_nz),
    .byte_cnt(gl_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Packet selection and assembly
  always_comb begin
    idle = (state_ff == stamp_enc_pkg::ST_IDLE);
    // Overflow first, then local, low part, and the queued high part last
    sel_ovf = idle && ovf_pend_ff;
    sel_lts = idle && !ovf_pend_ff && local_req.valid && ctrl_ff[0];
    sel_gl = idle && !ovf_pend_ff && !sel_lts && global_req.valid && ctrl_ff[1];
    sel_gh = idle && !ovf_pend_ff && !sel_lts && !sel_gl && hi_pend_ff;
    lts_single = (local_req.stamp_relation_code == stamp_enc_pkg::REL_SYNC) &&
                 (ctr_ff >= 28'(stamp_enc_pkg::SINGLE_MIN)) &&
                 (ctr_ff <= 28'(stamp_enc_pkg::SINGLE_MAX));
    gl_wrap = ts_high != hi_last_ff;
    gl_full = gl_wrap || clk_flag_ff || full_req_ff;
    gl_len = gl_full ? stamp_enc_pkg::LOW_FULL_GROUPS : gl_cnt;
    gl_grp3 = {gl_wrap, clk_flag_ff, ts_low[25:21]};
    pkt = '0;
    pkt_rem = stamp_enc_pkg::NO_PAYLOAD;
    if (sel_ovf) begin
      pkt[0] = stamp_enc_pkg::OVERFLOW_HEADER;
    end else if (sel_lts && lts_single) begin
      pkt[0] = {1'b0, ctr_ff[2:0], stamp_enc_pkg::LOCAL_HEADER_LOW};
    end else if (sel_lts) begin
      // Relation code passes straight into the header
      pkt[0] = {2'b11, local_req.stamp_relation_code,
                stamp_enc_pkg::LOCAL_HEADER_LOW};
      pkt_rem = lts_len;
      for (int i = 0; i < 4; i++) begin
        pkt[i+1] = {3'(i + 1) < lts_len, ctr_ff[i*7 +: 7]};
      end
    end else if (sel_gl) begin
      pkt[0] = stamp_enc_pkg::LOW_PART_HEADER;
      pkt_rem = gl_len;
      for (int i = 0; i < 3; i++) begin
        pkt[i+1] = {3'(i + 1) < gl_len, ts_low[i*7 +: 7]};
      end
      pkt[4] = {1'b0, gl_grp3};
    end else if (sel_gh) begin
      pkt[0] = stamp_enc_pkg::HIGH_PART_HEADER;
      pkt_rem = stamp_enc_pkg::HIGH_PART_PAYLOAD;
      for (int i = 0; i < 3; i++) begin
        pkt[i+1] = {1'b1, hi_q_ff[i*7 +: 7]};
      end
      // Wide build: byte 3 continues and carries bits 53..47
      pkt[4] = {1'b1, hi_q_ff[27:22], hi_q_ff[21]};
      pkt[5] = {1'b1, hi_q_ff[34:28]};
      // Last byte of a 7-byte packet has no continuation meaning
      pkt[6] = {5'h00, hi_q_ff[37:35]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stream and stamp state
  always_comb begin
    nxt_state = state_ff;
    nxt_out_data = out_data_ff;
    nxt_out_valid = out_valid_ff;
    nxt_buf = buf_ff;
    nxt_rem = rem_ff;
    if (out_valid_ff && out_ready) begin
      if (rem_ff != stamp_enc_pkg::NO_PAYLOAD) begin
        nxt_out_data = buf_ff[0];
        nxt_buf = {8'h00, buf_ff[5:1]};
        nxt_rem = rem_ff - 3'h1;
      end else begin
        nxt_out_valid = 1'b0;
        nxt_state = stamp_enc_pkg::ST_IDLE;
      end
    end
    if (sel_ovf || sel_lts || sel_gl || sel_gh) begin
      nxt_out_data = pkt[0];
      nxt_out_valid = 1'b1;
      nxt_buf = pkt[6:1];
      nxt_rem = pkt_rem;
      nxt_state = stamp_enc_pkg::ST_SEND;
    end
    // Counter restarts when a local packet leaves, and wraps to zero from all ones
    nxt_ctr = sel_lts ? '0 : ctr_ff + 28'h1;
    nxt_ovf_pend = (ovf_pend_ff && !sel_ovf) || (!sel_lts && (&ctr_ff));
    nxt_clk_flag = clock_change || (clk_flag_ff && !sel_gl);
    nxt_full_req = (apb_wr && paddr == stamp_enc_pkg::CTRL_OFFSET &&
                    pwdata[stamp_enc_pkg::CTRL_FORCE_FULL_BIT]) ||
                   (full_req_ff && !sel_gl);
    nxt_hi_pend = (sel_gl && gl_full) || (hi_pend_ff && !sel_gh);
    // Queued high part follows the newest low part sent
    nxt_hi_q = (sel_gl && (gl_full || hi_pend_ff)) ? ts_high : hi_q_ff;
    nxt_hi_last = sel_gh ? hi_q_ff : hi_last_ff;
    nxt_low_last = sel_gl ? ts_low : low_last_ff;
    // Requests lost to a busy output are only counted
    nxt_drops = drops_ff + 16'((local_req.valid && ctrl_ff[0] && !sel_lts) ||
                               (global_req.valid && ctrl_ff[1] && !sel_gl));
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  always_comb begin
    apb_setup = psel && !penable;
    apb_wr = psel && penable && pready_ff && pwrite;
    nxt_pready = apb_setup;
    nxt_pslverr = 1'b0;
    nxt_prdata = 32'h0000_0000;
    nxt_ctrl = ctrl_ff;
    if (apb_setup) begin
      unique case (paddr)
        stamp_enc_pkg::CTRL_OFFSET: nxt_prdata = {30'h0, ctrl_ff};
        stamp_enc_pkg::STATUS_OFFSET: nxt_prdata = {28'h0, clk_flag_ff, ovf_pend_ff,
                                                    out_valid_ff, hi_pend_ff};
        stamp_enc_pkg::DROPS_OFFSET: nxt_prdata = {16'h0, drops_ff};
        default: nxt_pslverr = 1'b1;
      endcase
    end
    if (apb_wr && paddr == stamp_enc_pkg::CTRL_OFFSET) begin
      nxt_ctrl = pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= stamp_enc_pkg::ST_IDLE;
      out_data_ff <= 8'h00;
      out_valid_ff <= 1'b0;
      buf_ff <= '0;
      rem_ff <= 3'h0;
      ctr_ff <= '0;
      ovf_pend_ff <= 1'b0;
      clk_flag_ff <= 1'b0;
      full_req_ff <= 1'b1;
      hi_pend_ff <= 1'b0;
      hi_q_ff <= '0;
      hi_last_ff <= '0;
      low_last_ff <= '0;
      drops_ff <= '0;
      ctrl_ff <= stamp_enc_pkg::CTRL_RESET;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      out_data_ff <= nxt_out_data;
      out_valid_ff <= nxt_out_valid;
      buf_ff <= nxt_buf;
      rem_ff <= nxt_rem;
      ctr_ff <= nxt_ctr;
      ovf_pend_ff <= nxt_ovf_pend;
      clk_flag_ff <= nxt_clk_flag;
      full_req_ff <= nxt_full_req;
      hi_pend_ff <= nxt_hi_pend;
      hi_q_ff <= nxt_hi_q;
      hi_last_ff <= nxt_hi_last;
      low_last_ff <= nxt_low_last;
      drops_ff <= nxt_drops;
      ctrl_ff <= nxt_ctrl;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign out_data = out_data_ff;
  assign out_valid = out_valid_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_SINGLE_FORM: assert property (clk_en && sel_lts && lts_single |=>
    !out_data_ff[7] && out_data_ff[6:4] == $past(ctr_ff[2:0]))
    else $error("single local form wrong");
  AST_SINGLE_RANGE: assert property (clk_en && sel_lts && lts_single |=>
    out_data_ff[6:4] != 3'h0 && out_data_ff[6:4] != 3'h7 && out_data_ff[3:0] == 4'h0)
    else $error("single local value out of range");
  AST_MULTI_HEADER: assert property (clk_en && sel_lts && !lts_single |=>
    out_data_ff[7:6] == 2'b11 && out_data_ff[5:4] == $past(local_req.stamp_relation_code))
    else $error("multi local header wrong");
  AST_LOCAL_LEN: assert property (clk_en && sel_lts && !lts_single |=>
    rem_ff == $past(lts_len) && rem_ff != 3'h0)
    else $error("local payload count wrong");
  AST_CTR_CLEAR: assert property (clk_en && sel_lts |=> ctr_ff == '0)
    else $error("local counter not cleared");
  AST_OVF_BYTE: assert property (clk_en && sel_ovf |=>
    out_valid_ff && out_data_ff == 8'h70 && rem_ff == 3'h0)
    else $error("overflow packet wrong");
  AST_LOW_HEADER: assert property (clk_en && sel_gl |=> out_data_ff == 8'h94)
    else $error("low part header wrong");
  AST_HIGH_FULL: assert property (clk_en && sel_gh |=>
    out_data_ff == 8'hb4 && rem_ff == 3'h6)
    else $error("high part not full length");
  AST_QUEUE_HIGH: assert property (clk_en && sel_gl && gl_full |=> hi_pend_ff)
    else $error("high part not queued");
  AST_CLK_FLAG: assert property (clk_en && clock_change |=> clk_flag_ff)
    else $error("clock change lost");

  AST_GLOBAL_LEN: assert property (clk_en && sel_gl |=>
    rem_ff != 3'h0 && rem_ff <= 3'h4)
    else $error("low part payload count wrong");

  AST_FULL_FORCED: assert property (clk_en && sel_gl && clk_flag_ff |=> rem_ff == 3'h4)
    else $error("clock change did not force full value");
  AST_HOLD_BYTE: assert property (out_valid_ff && !out_ready |=>
    out_valid_ff && $stable(out_data_ff))
    else $error("byte changed before accept");

  COV_SINGLE: cover property (clk_en && sel_lts && lts_single);
  COV_MULTI4: cover property (clk_en && sel_lts && lts_len == 3'h4);
  COV_FULL_GLOBAL: cover property (clk_en && sel_gl && gl_full ##[1:40] clk_en && sel_gh);
  COV_OVERFLOW: cover property (clk_en && sel_ovf);

endmodule : trace_timestamp_packet_encoder

`default_nettype wire

// ---- stamp_enc_pkg.sv ----
// Constants and carrier types of the trace timestamp packet encoder.
// Assumes a single trace clock domain and a 32-bit APB register port.
`default_nettype none

package stamp_enc_pkg;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] DROPS_OFFSET = 12'h008;

  // Control fields
  localparam int CTRL_LOCAL_EN_BIT = 0;
  localparam int CTRL_GLOBAL_EN_BIT = 1;
  localparam int CTRL_FORCE_FULL_BIT = 2;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  // Status fields
  localparam int STATUS_HIGH_PEND_BIT = 0;
  localparam int STATUS_BUSY_BIT = 1;
  localparam int STATUS_OVF_PEND_BIT = 2;
  localparam int STATUS_CLK_FLAG_BIT = 3;

  // Stamp widths
  localparam int LOCAL_WIDTH = 28;
  localparam int GLOBAL_WIDTH = 64;
  localparam int GLOBAL_LOW_WIDTH = 26;
  localparam int GLOBAL_HIGH_WIDTH = GLOBAL_WIDTH - GLOBAL_LOW_WIDTH;
  localparam int GROUP_BITS = 7;
  localparam int DROPS_WIDTH = 16;

  // Packet bytes and lengths
  localparam logic [7:0] OVERFLOW_HEADER = 8'h70;
  localparam logic [7:0] LOW_PART_HEADER = 8'h94;
  localparam logic [7:0] HIGH_PART_HEADER = 8'hb4;
  localparam logic [3:0] LOCAL_HEADER_LOW = 4'h0;
  localparam logic [2:0] SINGLE_MIN = 3'h1;
  localparam logic [2:0] SINGLE_MAX = 3'h6;
  localparam logic [1:0] REL_SYNC = 2'h0;
  localparam logic [2:0] LOW_FULL_GROUPS = 3'h4;
  localparam logic [2:0] HIGH_PART_PAYLOAD = 3'h6;
  localparam logic [2:0] NO_PAYLOAD = 3'h0;

  // Local stamp request with its relation code
  typedef struct packed {
    logic valid;
    logic [1:0] stamp_relation_code;
  } local_req_type;

  // Global stamp request with the sampled absolute value
  typedef struct packed {
    logic valid;
    logic [GLOBAL_WIDTH-1:0] stamp_value_field;
  } global_req_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01
  } enc_state_type;

endpackage : stamp_enc_pkg

`default_nettype wire

// ---- stamp_group_len.sv ----
// Payload byte count from a mask of non-empty 7-bit groups.
// Assumes four groups, lowest group first; at least one byte is always kept.
`default_nettype none

module stamp_group_len (
  // Group mask
  input wire logic [3:0] group_nz,
  // Result
  output logic [2:0] byte_cnt
);

  always_comb begin
    byte_cnt = 3'h1;
    for (int i = 1; i < 4; i++) begin
      if (group_nz[i]) begin
        byte_cnt = 3'(i + 1);
      end
    end
  end

endmodule : stamp_group_len

`default_nettype wire

// ---- trace_sink_model.sv ----
// Trace sink model: takes packet bytes, with an optional stall pattern.
// Assumes the encoder holds each byte until it sees out_ready high.
`default_nettype none

module trace_sink_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Byte stream
  input wire logic [7:0] out_data,
  input wire logic out_valid,
  output logic out_ready,
  // Pacing
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  logic [1:0] pace_ff;
  ////////////////////////////////////////////////////////////////
  // Stall two cycles in four when slow, so held bytes get tested
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pace_ff <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      pace_ff <= pace_ff + 2'h1;
      out_ready <= !slow || pace_ff[1];
    end
  end
  // A byte counts only at the accepting edge
  always @(posedge ref_clk) begin
    if (rst_n && out_valid && out_ready) begin
      got.push_back(out_data);
    end
  end
endmodule : trace_sink_model

`default_nettype wire

// ---- trace_timestamp_packet_encoder_test.sv ----
// Testbench: local and global stamp streams, APB registers, drops.
// Assumes zero-wait APB and a sink model that may stall.
`default_nettype none

module trace_timestamp_packet_encoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, clk_en, psel, penable, pwrite, pslverr, pready, clock_change;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  stamp_enc_pkg::local_req_type local_req;
  stamp_enc_pkg::global_req_type global_req;
  logic [7:0] out_data;
  logic out_valid, out_ready, slow;
  int bad_count, checks_done, cyc;
  ////////////////////////////////////////////////////////////////
  trace_timestamp_packet_encoder dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .local_req(local_req), .global_req(global_req),
    .clock_change(clock_change), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready)
  );
  trace_sink_model sink_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready), .slow(slow)
  );
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Whole run is about 21k cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic wait_quiet();
    int k;
    k = 0;
    while (k < 4) begin
      @(posedge ref_clk);
      k = out_valid ? 0 : k + 1;
    end
  endtask : wait_quiet

  task automatic send_g(input logic [63:0] v);
    global_req <= {1'b1, v};
    @(posedge ref_clk);
    global_req <= '0;
    wait_quiet();
  endtask : send_g

  // Low part then its queued high part, compared byte by byte
  task automatic gcheck(input logic [63:0] v, input bit full, input bit clk, input bit wrp);
    logic [7:0] g[$];
    g = sink_u.got;
    sink_u.got.delete();
    check("gl_size", g.size(), full ? 12 : 2);
    check("gl_head", g[0], 8'h94);
    if (!full) begin
      check("gl_p0", g[1], {1'b0, v[6:0]});
      return;
    end
    for (int k = 0; k < 3; k++) check("gl_grp", g[k + 1], {1'b1, v[7*k +: 7]});
    check("gl_last", {g[4][7], g[4][5:0]}, {1'b0, clk, v[25:21]});
    check("gl_wrap", g[4][6], wrp);
    check("gh_head", g[5], 8'hb4);
    for (int k = 0; k < 3; k++) check("gh_grp", g[k + 6], {1'b1, v[26+7*k +: 7]});
    check("gh_b3", g[9], {1'b1, v[53:48], v[47]});
    check("gh_b4", g[10], {1'b1, v[60:54]});
    check("gh_b5", g[11], {5'h00, v[63:61]});
  endtask : gcheck
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rd, v, c;
    logic er;
    logic [7:0] h, b;
    int p, n, t0;
    logic [1:0] rels[7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
    int gaps[6] = '{40, 5, 6, 200, 20000, 300};
    logic [63:0] gv;
    rst_n = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    local_req = '0;
    global_req = '0;
    clock_change = 1'b0;
    slow = 1'b0;
    c = 32'h0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, stamp_enc_pkg::CTRL_OFFSET, 32'h0, rd, er);
    check("ctrl_rst", rd, 32'h3);
    apb(1'b0, 12'h00c, 32'h0, rd, er);
    check("unmapped", {rd[30:0], er}, 32'h1);
    // Local stamps at varied spacing; deltas must track the spacing
    for (int i = 0; i < 7; i++) begin
      t0 = cyc;
      local_req <= {1'b1, rels[i]};
      @(posedge ref_clk);
      local_req <= '0;
      if (i < 6) while (cyc < t0 + gaps[i]) @(posedge ref_clk);
    end
    wait_quiet();
    p = 0;
    for (int i = 0; i < 7; i++) begin
      h = sink_u.got[p];
      p++;
      check("lts_low", h[3:0], 4'h0);
      if (!h[7]) begin
        check("single_val", 32'(h[6:4] inside {[1:6]}), 1);
        check("single_rel", rels[i], 2'h0);
        v = 32'(h[6:4]);
      end else begin
        check("multi_b6", h[6], 1'b1);
        check("rel", h[5:4], rels[i]);
        v = 32'h0;
        n = 0;
        do begin
          b = sink_u.got[p];
          p++;
          v = v | (32'(b[6:0]) << (7 * n));
          n++;
        end while (b[7] && n < 4);
        check("top_group", 32'(n == 1 || b[6:0] != 7'h0), 1);
        check("no_short", 32'(rels[i] == 2'h0 && v inside {[1:6]}), 0);
      end
      if (i == 1) c = v - gaps[0];
      else if (i > 1) check("delta", v - gaps[i-1], c);
    end
    check("lts_bytes", p, sink_u.got.size());
    sink_u.got.delete();
    // Global stamps through a stalling sink
    slow <= 1'b1;
    gv = 64'h9bd3_5713_a5c6_e38d;
    send_g(gv);
    gcheck(gv, 1'b1, 1'b0, 1'b1);
    gv = gv ^ 64'h5;
    send_g(gv);
    gcheck(gv, 1'b0, 1'b0, 1'b0);
    clock_change <= 1'b1;
    @(posedge ref_clk);
    clock_change <= 1'b0;
    gv = gv ^ 64'h4000_0002;
    send_g(gv);
    gcheck(gv, 1'b1, 1'b1, 1'b1);
    // Local request while busy is dropped and counted
    global_req <= {1'b1, gv ^ 64'h1};
    @(posedge ref_clk);
    global_req <= '0;
    local_req <= {1'b1, 2'h0};
    @(posedge ref_clk);
    local_req <= '0;
    wait_quiet();
    gcheck(gv ^ 64'h1, 1'b0, 1'b0, 1'b0);
    // Disabled local source gives nothing and counts nothing
    apb(1'b1, stamp_enc_pkg::CTRL_OFFSET, 32'h2, rd, er);
    apb(1'b0, stamp_enc_pkg::CTRL_OFFSET, 32'h0, rd, er);
    check("ctrl_rw", rd, 32'h2);
    local_req <= {1'b1, 2'h0};
    @(posedge ref_clk);
    local_req <= '0;
    wait_quiet();
    check("disabled", sink_u.got.size(), 0);
    // Forced full value of an unchanged stamp, wrap stays clear
    apb(1'b1, stamp_enc_pkg::CTRL_OFFSET, 32'h6, rd, er);
    send_g(gv ^ 64'h1);
    gcheck(gv ^ 64'h1, 1'b1, 1'b0, 1'b0);
    apb(1'b0, stamp_enc_pkg::DROPS_OFFSET, 32'h0, rd, er);
    check("drops", rd, 32'h1);
    apb(1'b0, stamp_enc_pkg::STATUS_OFFSET, 32'h0, rd, er);
    check("status", rd, 32'h0);
    wrap_up();
  end
endmodule : trace_timestamp_packet_encoder_test

`default_nettype wire
